// >>> src/cfg_loader_pkg.sv
// constants and types shared by the serial configuration loader
`default_nettype none
package cfg_loader_pkg;
	// ==========================================================
	// mode pin codes
	localparam logic [2:0] MODE_SERIAL_MASTER = 3'h0;
	localparam logic [2:0] MODE_SPI_FLASH     = 3'h1;
	localparam logic [2:0] MODE_SERIAL_SLAVE  = 3'h7;
	// ==========================================================
	// flash variants and their read commands
	localparam logic [2:0] VARIANT_FAST_READ  = 3'h7;
	localparam logic [2:0] VARIANT_READ       = 3'h5;
	localparam logic [7:0] CMD_FAST_READ      = 8'h0B;
	localparam logic [7:0] CMD_READ           = 8'h03;
	localparam logic [1:0] DUMMY_FAST_READ    = 2'h1;
	localparam logic [1:0] DUMMY_READ         = 2'h0;
	// ==========================================================
	// clocking
	localparam int CLOCK_MHZ        = 100;
	localparam int LOWEST_RATE_MHZ  = 1;
	localparam int PROGRAM_LOW_NS   = 500;
	localparam int PROGRAM_LOW_CYC  = (PROGRAM_LOW_NS * CLOCK_MHZ + 999) / 1000;
	localparam int CLEAR_CYCLES     = 16;
	// ==========================================================
	// load sequence
	typedef enum logic [2:0] {
		ST_CLEAR   = 3'b000,
		ST_SAMPLE  = 3'b001,
		ST_COMMAND = 3'b010,
		ST_DUMMY   = 3'b011,
		ST_LOAD    = 3'b100,
		ST_DONE    = 3'b101,
		ST_ERROR   = 3'b110
	} load_state_t;
endpackage
`default_nettype wire

// >>> src/clock_divider.sv
// configuration clock generator dividing the internal oscillator
`timescale 1ns/1ps
`default_nettype none
module clock_divider
	import cfg_loader_pkg::*;
#(
	parameter int CLOCK_FREQ_MHZ = CLOCK_MHZ
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       run,
	input  wire logic [7:0] rateMhz,
	output logic            clkOut,
	output logic            riseTick,
	output logic            fallTick
);
	// ==========================================================
	// half-period counter
	logic [7:0] half_q;
	logic [7:0] cnt_q;

	function automatic logic [7:0] halfPeriod(input logic [7:0] mhz);
		int h;
		int m;
		m = (mhz == 8'h00) ? 1 : int'(mhz);
		// round the half period up so the clock never beats the option
		h = (CLOCK_FREQ_MHZ + 2 * m - 1) / (2 * m);
		return (h < 1) ? 8'h01 : 8'(h);
	endfunction

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= 8'h00;
			clkOut <= 1'b0;
			half_q <= 8'h01;
		end else begin
			half_q <= halfPeriod(rateMhz);
			if (!run) begin
				cnt_q  <= 8'h00;
				clkOut <= 1'b0;
			end else if (cnt_q + 8'h01 >= half_q) begin
				cnt_q  <= 8'h00;
				clkOut <= ~clkOut;
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end

	always_comb begin
		riseTick = run && (cnt_q + 8'h01 >= half_q) && !clkOut;
		fallTick = run && (cnt_q + 8'h01 >= half_q) && clkOut;
	end
endmodule // clock_divider
`default_nettype wire

// >>> src/serial_config_master_loader.sv
// serial configuration master: clocks a config memory and loads the stream
`timescale 1ns/1ps
`default_nettype none
module serial_config_master_loader
	import cfg_loader_pkg::*;
#(
	parameter int STREAM_BITS = 64,
	parameter int CLEAR_LEN   = CLEAR_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic [2:0]  config_mode_select,
	input  wire logic [2:0]  flash_variant_select,
	input  wire logic [7:0]  clock_rate_option,
	input  wire logic        program_request_n,
	input  wire logic        serial_data_in,
	input  wire logic        speedUpRequest,
	input  wire logic        crcMismatch,
	input  wire logic        userTakeover,
	input  wire logic        userClock,
	input  wire logic        userSelect,
	input  wire logic        userData,
	output logic             config_clock_out,
	output logic             serial_data_out,
	output logic             flashSelect_n,
	output logic             flashMosi,
	output logic             init_indicator_n,
	output logic             initOe,
	output logic             load_complete,
	output logic             loadedBit,
	output logic             loadedValid,
	output logic             userDataIn
);
	// ==========================================================
	// reset release and input sync
	logic [1:0] rst_q;
	logic       rst_n;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) rst_q <= 2'h0;
		else rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n = rst_q[1];

	logic [2:0] prog_q;
	logic [2:0] din_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prog_q <= 3'h7;
			din_q  <= 3'h0;
		end else begin
			prog_q <= {prog_q[1:0], program_request_n};
			din_q  <= {din_q[1:0], serial_data_in};
		end
	end
	logic progLow;
	logic dinBit;
	assign progLow = !prog_q[1] && !prog_q[2];
	assign dinBit  = din_q[2];

	// ==========================================================
	// program pulse width
	logic [15:0] progCnt_q;
	logic        restart_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			progCnt_q <= 16'h0000;
			restart_q <= 1'b0;
		end else if (progLow) begin
			if (progCnt_q < 16'(PROGRAM_LOW_CYC)) progCnt_q <= progCnt_q + 16'h0001;
			else restart_q <= 1'b1;
		end else begin
			progCnt_q <= 16'h0000;
			restart_q <= 1'b0;
		end
	end
	logic holdClear;
	assign holdClear = restart_q || (progLow && progCnt_q >= 16'(PROGRAM_LOW_CYC));

	// ==========================================================
	// clock rate
	logic [7:0] rate_q;
	logic       run;
	logic       clkGen;
	logic       riseTick;
	logic       fallTick;
	load_state_t state_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) rate_q <= 8'(LOWEST_RATE_MHZ);
		else if (holdClear || state_q == ST_CLEAR) rate_q <= 8'(LOWEST_RATE_MHZ);
		else if (speedUpRequest && state_q == ST_LOAD) rate_q <= clock_rate_option;
	end

	// internal oscillator only, no external clock input
	clock_divider #(.CLOCK_FREQ_MHZ(CLOCK_MHZ)) u_clock_divider (
		.clock    (clock),
		.rst_n    (rst_n),
		.run      (run),
		.rateMhz  (rate_q),
		.clkOut   (clkGen),
		.riseTick (riseTick),
		.fallTick (fallTick)
	);

	// ==========================================================
	// load sequence
	logic [2:0]  mode_q;
	logic [7:0]  cmd_q;
	logic [1:0]  dummy_q;
	logic [15:0] cnt_q;
	logic [31:0] bits_q;
	logic        spi;
	logic [7:0]  firstCmd;
	assign spi = (mode_q == MODE_SPI_FLASH);

	function automatic logic [7:0] readCommand(input logic [2:0] vsel);
		return (vsel == VARIANT_FAST_READ) ? CMD_FAST_READ : CMD_READ;
	endfunction
	// first command bit must stand before the first rising edge
	assign firstCmd = readCommand(flash_variant_select);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_CLEAR;
			mode_q  <= MODE_SERIAL_MASTER;
			cmd_q   <= CMD_READ;
			dummy_q <= DUMMY_READ;
			cnt_q   <= 16'h0000;
			bits_q  <= 32'h0;
		end else if (holdClear) begin
			state_q <= ST_CLEAR;
			cnt_q   <= 16'h0000;
			bits_q  <= 32'h0;
		end else begin
			case (state_q)
				ST_CLEAR: begin
					if (cnt_q >= 16'(CLEAR_LEN)) state_q <= ST_SAMPLE;
					else cnt_q <= cnt_q + 16'h0001;
				end
				ST_SAMPLE: begin
					mode_q <= config_mode_select;
					cnt_q  <= 16'h0000;
					cmd_q <= readCommand(flash_variant_select);
					if (flash_variant_select == VARIANT_FAST_READ) begin
						dummy_q <= DUMMY_FAST_READ;
					end else begin
						dummy_q <= DUMMY_READ;
					end
					state_q <= (config_mode_select == MODE_SPI_FLASH) ? ST_COMMAND : ST_LOAD;
				end
				ST_COMMAND: if (fallTick) begin
					// command plus 24-bit zero address
					if (cnt_q == 16'd31) begin
						cnt_q   <= 16'h0000;
						state_q <= (dummy_q == 2'h0) ? ST_LOAD : ST_DUMMY;
					end else cnt_q <= cnt_q + 16'h0001;
				end
				ST_DUMMY: if (fallTick) begin
					if (cnt_q == {11'h0, dummy_q, 3'h0} - 16'h0001) begin
						cnt_q   <= 16'h0000;
						state_q <= ST_LOAD;
					end else cnt_q <= cnt_q + 16'h0001;
				end
				ST_LOAD: begin
					if (crcMismatch) state_q <= ST_ERROR;
					else if (riseTick) begin
						bits_q <= bits_q + 32'h1;
						if (bits_q == 32'(STREAM_BITS - 1)) state_q <= ST_DONE;
					end
				end
				ST_DONE: state_q <= ST_DONE;
				ST_ERROR: state_q <= ST_ERROR;
				default: state_q <= ST_CLEAR;
			endcase
		end
	end

	// clock stops at done in SPI flash mode or under user takeover; chain forwarding keeps it in every other mode
	assign run = (state_q == ST_COMMAND) || (state_q == ST_DUMMY) || (state_q == ST_LOAD)
		|| (state_q == ST_DONE && !spi && !userTakeover);

	// ==========================================================
	// pins
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			config_clock_out <= 1'b0;
			serial_data_out  <= 1'b0;
			flashSelect_n    <= 1'b1;
			flashMosi        <= 1'b0;
			init_indicator_n <= 1'b0;
			initOe           <= 1'b1;
			load_complete    <= 1'b0;
			loadedBit        <= 1'b0;
			loadedValid      <= 1'b0;
			userDataIn       <= 1'b0;
		end else begin
			// pins handed to user logic after completion
			if (state_q == ST_DONE && userTakeover) begin
				config_clock_out <= userClock;
				flashSelect_n    <= userSelect;
				flashMosi        <= userData;
			end else begin
				config_clock_out <= clkGen;
				flashSelect_n    <= !(spi && (state_q == ST_COMMAND || state_q == ST_DUMMY
					|| state_q == ST_LOAD));
				if (state_q == ST_SAMPLE)
					flashMosi <= firstCmd[7];
				else if (fallTick && state_q == ST_COMMAND)
					flashMosi <= (cnt_q < 16'd7) ? cmd_q[3'(6 - cnt_q[2:0])] : 1'b0;
			end
			userDataIn <= dinBit;
			// forwarding to next chain device on falling edge
			if (fallTick && state_q == ST_DONE && !spi) serial_data_out <= dinBit;
			loadedValid <= riseTick && state_q == ST_LOAD;
			if (riseTick && state_q == ST_LOAD) loadedBit <= dinBit;
			// open-drain: drive low during clearing or on error
			initOe           <= (state_q == ST_CLEAR) || (state_q == ST_ERROR) || holdClear;
			init_indicator_n <= 1'b0;
			load_complete    <= (state_q == ST_DONE) && !holdClear;
		end
	end
endmodule // serial_config_master_loader
`default_nettype wire

// >>> test/cfg_mem_model.sv
// serial configuration memory model
`timescale 1ns/1ps
`default_nettype none
module cfg_mem_model #(
	parameter logic [7:0] PAT = 8'hC6
) (
	input  wire logic sck,
	input  wire logic hold,
	output logic      dout
);
	logic [2:0] idx_q;
	// ====
	// address counter cleared by init, data moves on falling clock
	always @(negedge sck or posedge hold) begin
		if (hold)
			idx_q <= 3'h0;
		else
			idx_q <= idx_q + 3'h1;
	end
	// while held the line shows no stale bit
	assign dout = hold ? ~PAT[7] : PAT[3'h7 - idx_q];
endmodule // cfg_mem_model
`default_nettype wire

// >>> test/serial_config_master_loader_props.sv
// port assertions for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module serial_config_master_loader_props (
	input wire logic       clock,
	input wire logic       nrst,
	input wire logic [7:0] clock_rate_option,
	input wire logic       program_request_n,
	input wire logic       speedUpRequest,
	input wire logic       crcMismatch,
	input wire logic       userTakeover,
	input wire logic       userClock,
	input wire logic       config_clock_out,
	input wire logic       flashSelect_n,
	input wire logic       initOe,
	input wire logic       load_complete,
	input wire logic       loadedValid
);
	logic [7:0] runLen_q;
	logic       live;
	logic       rateOk;
	logic       spiSeen_q;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!nrst);
	// ====
	// half period length, saturating so idle spans never count
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			runLen_q <= 8'hFF;
		else if (initOe)
			runLen_q <= 8'hFF;
		else if ($changed(config_clock_out))
			runLen_q <= 8'h01;
		else if (runLen_q != 8'hFF)
			runLen_q <= runLen_q + 8'h01;
	end
	// serial master keeps clocking after done to feed the chain
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			spiSeen_q <= 1'b0;
		else if (initOe)
			spiSeen_q <= 1'b0;
		else if (!flashSelect_n && !load_complete)
			spiSeen_q <= 1'b1;
	end
	assign live = !initOe && !load_complete && runLen_q != 8'hFF;
	assign rateOk = ({8'h00, runLen_q} + 16'h0001) * {8'h00, clock_rate_option} >= 16'h0032;
	start_rate_a: assert property ($changed(config_clock_out) && live && !speedUpRequest |-> runLen_q == 8'h32)
		else $error("start rate wrong");
	rate_limit_a: assert property ($changed(config_clock_out) && live |-> rateOk)
		else $error("rate above option");
	done_init_a: assert property ($rose(load_complete) |-> !initOe ##1 load_complete [*8])
		else $error("done unsteady");
	crc_error_a: assert property (crcMismatch && !initOe && !load_complete |-> ##[1:3] initOe)
		else $error("crc not flagged");
	prog_hold_a: assert property (!program_request_n && initOe |=> initOe && !load_complete)
		else $error("left clear early");
	clock_stop_a: assert property ((load_complete && !userTakeover && spiSeen_q) [*3] |-> !config_clock_out)
		else $error("clock runs after done");
	user_pins_a: assert property ((load_complete && userTakeover) [*2] |-> config_clock_out == $past(userClock))
		else $error("user clock lost");
	capture_edge_a: assert property (loadedValid |=> config_clock_out && !loadedValid)
		else $error("capture off edge");
endmodule // serial_config_master_loader_props
`default_nettype wire

// >>> test/test_serial_config_master_loader.sv
// self-checking bench for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module test_serial_config_master_loader;
	import cfg_loader_pkg::*;
	localparam logic [7:0] PAT = 8'hC6;
	logic       clock = 1'b0;
	logic       nrst = 1'b0;
	logic [2:0] config_mode_select = MODE_SERIAL_MASTER;
	logic [2:0] flash_variant_select = VARIANT_READ;
	logic [7:0] clock_rate_option = 8'h19;
	logic [7:0] cmd;
	logic       program_request_n = 1'b1;
	logic       speedUpRequest = 1'b0;
	logic       crcMismatch = 1'b0;
	logic       userTakeover = 1'b0;
	logic       userClock = 1'b0;
	logic       userSelect = 1'b1;
	logic       userData = 1'b0;
	logic       spiChk = 1'b0;
	logic       serial_data_in, config_clock_out, serial_data_out, flashSelect_n, flashMosi;
	logic       init_indicator_n, initOe, load_complete, loadedBit, loadedValid, userDataIn;
	logic       q[$];
	int         fails = 0;
	int         tests_run = 0;
	int         cyc = 0;
	serial_config_master_loader #(.STREAM_BITS(8), .CLEAR_LEN(4)) u_serial_config_master_loader (.*);
	cfg_mem_model #(.PAT(PAT)) u_cfg_mem_model (.sck(config_clock_out), .hold(initOe), .dout(serial_data_in));
	always #5 clock = ~clock;
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		tests_run++;
		if (seen !== want) begin
			fails++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic boot(input logic [2:0] mode, input logic [2:0] vsel);
		nrst = 1'b0;
		config_mode_select = mode;
		flash_variant_select = vsel;
		repeat (4) @(negedge clock);
		nrst = 1'b1;
	endtask
	task automatic noteStream();
		for (int i = 7; i >= 0; i--)
			q.push_back(PAT[i]);
	endtask
	task automatic finishLoad();
		while (!load_complete)
			@(negedge clock);
		check(8'(q.size()), 8'h00);
	endtask
	// ====
	// result watcher, oldest note first
	// sampled away from the launching edge
	always @(negedge clock) begin
		cyc++;
		if (!spiChk && loadedValid && q.size() > 0)
			check(loadedBit, q.pop_front());
		if (spiChk && $rose(config_clock_out) && !flashSelect_n && q.size() > 0)
			check(flashMosi, q.pop_front());
		if (cyc == 30000) begin
			fails++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(19));
		noteStream();
		boot(MODE_SERIAL_MASTER, VARIANT_READ);
		finishLoad();
		repeat (5) @(negedge clock);
		check(initOe, 1'b0);
		$display("serial load done");
		userTakeover = 1'b1;
		repeat (20) begin
			{userClock, userData} = 2'($urandom);
			repeat (2) @(negedge clock);
			check(config_clock_out, userClock);
		end
		userTakeover = 1'b0;
		$display("takeover done");
		clock_rate_option = 8'($urandom_range(12, 2));
		speedUpRequest = 1'b1;
		noteStream();
		boot(MODE_SERIAL_MASTER, VARIANT_READ);
		finishLoad();
		// speed request dropped only once held in clear
		program_request_n = 1'b0;
		repeat (70) @(negedge clock);
		check(load_complete, 1'b0);
		speedUpRequest = 1'b0;
		program_request_n = 1'b1;
		repeat (300) @(negedge clock);
		crcMismatch = 1'b1;
		repeat (120) @(negedge clock);
		crcMismatch = 1'b0;
		check(initOe, 1'b1);
		program_request_n = 1'b0;
		repeat (70) @(negedge clock);
		program_request_n = 1'b1;
		noteStream();
		finishLoad();
		$display("restart done");
		spiChk = 1'b1;
		for (int k = 0; k < 2; k++) begin
			cmd = k ? CMD_READ : CMD_FAST_READ;
			for (int i = 0; i < 32; i++)
				q.push_back(i < 8 ? cmd[7 - i] : 1'b0);
			boot(MODE_SPI_FLASH, k ? VARIANT_READ : VARIANT_FAST_READ);
			repeat (200) @(negedge clock);
			config_mode_select = MODE_SERIAL_SLAVE;
			finishLoad();
			$display("spi variant done");
		end
		print_verdict();
	end
endmodule // test_serial_config_master_loader
bind serial_config_master_loader serial_config_master_loader_props u_serial_config_master_loader_props (.*);
`default_nettype wire
